// >>> msd_decoder.sv
// Program and data memory space address decoder
// How it works
// - Program RAM is two 2K blocks at 0x0000 and 0x1800, not contiguous.
// - Program ROM is selected for the 2K window starting at 0x0800.
// - Data RAM is one 1K block selected from 0x3800.
// - Data 0x2000-0x20FF selects the peripheral registers, not RAM.
// - Data 0x3C00-0x3FFF selects the processor control registers.
// - Data 0x0000-0x1FFF and 0x2100-0x37FF select nothing.
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_decoder
  import msd_pkg::*;
#(
  parameter int PM_AW = 24,  // Program address width
  parameter int DM_AW = 16   // Data address width
) (
  input  wire logic             ref_clk,     // Core clock
  input  wire logic             rstn,        // Async reset, active low
  input  wire logic [PM_AW-1:0] pm_addr,     // Program memory address
  input  wire logic             pm_rd,       // Program read strobe
  input  wire logic             pm_wr,       // Program write strobe
  input  wire logic [23:0]      pm_rom_q,    // ROM read data
  input  wire logic [23:0]      pm_ram0_q,   // Program RAM block 0 data
  input  wire logic [23:0]      pm_ram1_q,   // Program RAM block 1 data
  input  wire logic [DM_AW-1:0] dm_addr,     // Data memory address
  input  wire logic             dm_rd,       // Data read strobe
  input  wire logic             dm_wr,       // Data write strobe
  input  wire logic [15:0]      dm_ram_q,    // Data RAM read data
  input  wire logic [15:0]      dm_per_q,    // Peripheral register data
  input  wire logic [15:0]      dm_ctl_q,    // Control register data
  output msd_pm_sel_t           pm_sel,      // Program block selects
  output logic                  pm_ram0_we,  // Program RAM 0 write
  output logic                  pm_ram1_we,  // Program RAM 1 write
  output logic [10:0]           pm_ofs,      // Offset within 2K block
  output msd_dm_sel_t           dm_sel,      // Data block selects
  output logic                  dm_ram_we,   // Data RAM write
  output logic                  dm_per_we,   // Peripheral write
  output logic                  dm_ctl_we,   // Control register write
  output logic [9:0]            dm_ofs,      // Offset within region
  output logic [23:0]           pm_rdata,    // Registered program read
  output logic [15:0]           dm_rdata     // Registered data read
);

  msd_pm_sel_t pm_sel_next;
  msd_dm_sel_t dm_sel_next;
  msd_pm_sel_t pm_sel_reg;
  msd_dm_sel_t dm_sel_reg;
  logic [13:0] pa;
  logic [13:0] da;
  logic        pm_hi;
  logic        dm_hi;

  // All checks below run on the core clock and sleep through reset
  default clocking dec_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // Upper address bits beyond the on-chip map must be zero to hit anything
  assign pa    = pm_addr[`MSD_PM_AW-1:0];
  assign da    = dm_addr[`MSD_DM_AW-1:0];
  assign pm_hi = (PM_AW > `MSD_PM_AW) ? |(pm_addr >> `MSD_PM_AW) : 1'b0;
  assign dm_hi = (DM_AW > `MSD_DM_AW) ? |(dm_addr >> `MSD_DM_AW) : 1'b0;

  function automatic logic in_rng(input logic [13:0] a,
                                  input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    pm_sel_next = '0;
    if (pm_hi) begin
      pm_sel_next.none = 1'b1;
    end else if (pa < `MSD_PM_ROM_BASE) begin
      pm_sel_next.ram0 = 1'b1;
    end else if (pa < `MSD_PM_HOLE_BASE) begin
      pm_sel_next.rom = 1'b1;
    end else if (pa < `MSD_PM_RAM1_BASE) begin
      pm_sel_next.none = 1'b1;
    end else if (pa < `MSD_PM_TOP_BASE) begin
      pm_sel_next.ram1 = 1'b1;
    end else begin
      pm_sel_next.none = 1'b1;
    end
  end

  always_comb begin
    dm_sel_next = '0;
    if (dm_hi) begin
      dm_sel_next.none = 1'b1;
    end else if (in_rng(da, `MSD_DM_PER_BASE, `MSD_DM_PER_LAST)) begin
      dm_sel_next.per = 1'b1;
    end else if (in_rng(da, `MSD_DM_RAM_BASE, `MSD_DM_RAM_LAST)) begin
      dm_sel_next.ram = 1'b1;
    end else if (in_rng(da, `MSD_DM_CTL_BASE, `MSD_DM_CTL_LAST)) begin
      dm_sel_next.ctl = 1'b1;
    end else begin
      dm_sel_next.none = 1'b1;
    end
  end

  // Selects are combinational so RAMs see them in the access cycle
  assign pm_sel     = pm_sel_next;
  assign dm_sel     = dm_sel_next;
  assign pm_ofs     = pa[`MSD_PM_OFS_W-1:0];
  assign dm_ofs     = da[`MSD_DM_RAM_OFS_W-1:0];
  assign pm_ram0_we = pm_wr & pm_sel_next.ram0;
  assign pm_ram1_we = pm_wr & pm_sel_next.ram1;
  assign dm_ram_we  = dm_wr & dm_sel_next.ram;
  assign dm_per_we  = dm_wr & dm_sel_next.per;
  assign dm_ctl_we  = dm_wr & dm_sel_next.ctl;

  // Remember which block was read; arrays answer one cycle later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pm_sel_reg <= '0;
    end else begin
      pm_sel_reg <= pm_rd ? pm_sel_next : '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dm_sel_reg <= '0;
    end else begin
      dm_sel_reg <= dm_rd ? dm_sel_next : '0;
    end
  end

  // Read mux zeroes data for holes and idle cycles
  always_comb begin
    pm_rdata = '0;
    if (pm_sel_reg.ram0) pm_rdata = pm_ram0_q;
    if (pm_sel_reg.ram1) pm_rdata = pm_ram1_q;
    if (pm_sel_reg.rom)  pm_rdata = pm_rom_q;
  end

  always_comb begin
    dm_rdata = '0;
    if (dm_sel_reg.ram) dm_rdata = dm_ram_q;
    if (dm_sel_reg.per) dm_rdata = dm_per_q;
    if (dm_sel_reg.ctl) dm_rdata = dm_ctl_q;
  end

  // A read is two steps: strobe with a select, then data a cycle later
  sequence s_pm_ram0_read;
    pm_rd && pm_sel.ram0;
  endsequence
  sequence s_pm_ram1_read;
    pm_rd && pm_sel.ram1;
  endsequence
  sequence s_pm_rom_read;
    pm_rd && pm_sel.rom;
  endsequence
  sequence s_pm_hole_read;
    pm_rd && pm_sel.none;
  endsequence
  sequence s_pm_data_zero;
    pm_rdata == '0;
  endsequence
  sequence s_dm_ram_read;
    dm_rd && dm_sel.ram;
  endsequence
  sequence s_dm_per_read;
    dm_rd && dm_sel.per;
  endsequence
  sequence s_dm_ctl_read;
    dm_rd && dm_sel.ctl;
  endsequence
  sequence s_dm_hole_read;
    dm_rd && dm_sel.none;
  endsequence
  sequence s_dm_data_zero;
    dm_rdata == '0;
  endsequence

  AST_PM_RAM0: assert property (
    (!pm_hi && pa < `MSD_PM_ROM_BASE) |-> pm_sel.ram0 && !pm_sel.ram1)
    else $error("ram0 window miss");
  AST_PM_RAM1: assert property (
    (!pm_hi && pa >= `MSD_PM_RAM1_BASE && pa < `MSD_PM_TOP_BASE)
      |-> pm_sel.ram1 && !pm_sel.ram0)
    else $error("ram1 window miss");
  AST_PM_ROM: assert property (
    pm_sel.rom == (!pm_hi && pa >= `MSD_PM_ROM_BASE
                   && pa < `MSD_PM_HOLE_BASE))
    else $error("rom select wrong");
  AST_PM_HOLE: assert property (
    (pm_hi || in_rng(pa, `MSD_PM_HOLE_BASE, `MSD_PM_HOLE_LAST)
     || pa >= `MSD_PM_TOP_BASE)
      |-> pm_sel.none && !pm_sel.ram0 && !pm_sel.ram1 && !pm_sel.rom)
    else $error("program hole selects something");
  AST_NO_WR_HOLE: assert property (
    pm_sel.none |-> !pm_ram0_we && !pm_ram1_we)
    else $error("write into program hole");
  AST_PM_RD_RAM0: assert property (
    s_pm_ram0_read |=> pm_rdata == pm_ram0_q)
    else $error("ram0 read data not routed");
  AST_PM_RD_RAM1: assert property (
    s_pm_ram1_read |=> pm_rdata == pm_ram1_q)
    else $error("ram1 read data not routed");
  AST_PM_RD_ROM: assert property (
    s_pm_rom_read |=> pm_rdata == pm_rom_q)
    else $error("rom read data not routed");
  AST_PM_ZERO_RD: assert property (
    s_pm_hole_read |=> s_pm_data_zero)
    else $error("program hole read not zero");
  AST_DM_RAM: assert property (
    dm_sel.ram == (!dm_hi && in_rng(da, `MSD_DM_RAM_BASE,
                                    `MSD_DM_RAM_LAST)))
    else $error("data ram select wrong");
  AST_DM_PER: assert property (
    dm_sel.per |-> !dm_sel.ram
      && in_rng(da, `MSD_DM_PER_BASE, `MSD_DM_PER_LAST))
    else $error("peripheral select wrong");
  AST_DM_CTL: assert property (
    (!dm_hi && in_rng(da, `MSD_DM_CTL_BASE, `MSD_DM_CTL_LAST))
      |-> dm_sel.ctl)
    else $error("control select missing");
  AST_DM_HOLE: assert property (
    (!dm_hi && (da < `MSD_DM_PER_BASE
                || in_rng(da, `MSD_DM_GAP_BASE, `MSD_DM_GAP_LAST)))
      |-> dm_sel.none && !dm_sel.ram && !dm_sel.per && !dm_sel.ctl)
    else $error("hole selects something");
  AST_DM_NO_WR_HOLE: assert property (
    dm_sel.none |-> !dm_ram_we && !dm_per_we && !dm_ctl_we)
    else $error("write into data hole");
  AST_DM_RD_RAM: assert property (
    s_dm_ram_read |=> dm_rdata == dm_ram_q)
    else $error("data ram read not routed");
  AST_DM_RD_PER: assert property (
    s_dm_per_read |=> dm_rdata == dm_per_q)
    else $error("peripheral read not routed");
  AST_DM_RD_CTL: assert property (
    s_dm_ctl_read |=> dm_rdata == dm_ctl_q)
    else $error("control read not routed");
  AST_ZERO_RD: assert property (
    s_dm_hole_read |=> s_dm_data_zero)
    else $error("hole read not zero");

endmodule // msd_decoder

// >>> msd_cfg.svh
// Address map constants for the memory space decoder
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
`define MSD_PM_AW        14
`define MSD_DM_AW        14
`define MSD_PM_RAM0_BASE 14'h0000
`define MSD_PM_ROM_BASE  14'h0800
`define MSD_PM_HOLE_BASE 14'h1000
`define MSD_PM_RAM1_BASE 14'h1800
`define MSD_PM_TOP_BASE  14'h2000
`define MSD_PM_BLK_SH    11
`define MSD_DM_PER_BASE  14'h2000
`define MSD_DM_PER_LAST  14'h20ff
`define MSD_DM_RAM_BASE  14'h3800
`define MSD_DM_RAM_LAST  14'h3bff
`define MSD_DM_CTL_BASE  14'h3c00
`define MSD_DM_CTL_LAST  14'h3fff
`define MSD_PM_HOLE_LAST 14'h17ff
`define MSD_DM_GAP_BASE  14'h2100
`define MSD_DM_GAP_LAST  14'h37ff
`define MSD_PM_OFS_W     11
`define MSD_DM_RAM_OFS_W 10
`define MSD_DM_PER_OFS_W 8
`endif

// >>> msd_pkg.sv
// Types for the memory space decoder
package msd_pkg;
  typedef struct packed {
    logic ram0;
    logic ram1;
    logic rom;
    logic none;
  } msd_pm_sel_t;
  typedef struct packed {
    logic ram;
    logic per;
    logic ctl;
    logic none;
  } msd_dm_sel_t;
endpackage

// >>> msd_core_mem_model.sv
// Core-side memory arrays answering reads one cycle later
`timescale 1ns/1ps
module msd_core_mem_model (
  input  wire logic        ref_clk,  // Core clock
  input  wire logic [23:0] pm_addr,  // Program address
  input  wire logic        pm_rd,    // Program read
  input  wire logic [15:0] dm_addr,  // Data address
  input  wire logic        dm_rd,    // Data read
  output logic      [23:0] rom_q,    // ROM data
  output logic      [23:0] ram0_q,   // Program RAM 0 data
  output logic      [23:0] ram1_q,   // Program RAM 1 data
  output logic      [15:0] dram_q,   // Data RAM data
  output logic      [15:0] per_q,    // Peripheral data
  output logic      [15:0] ctl_q     // Control data
);
  // Data flips outside reads so a stale pick cannot match
  always @(posedge ref_clk) begin
    if (pm_rd) begin
      ram0_q <= {12'ha00, pm_addr[11:0]};
      ram1_q <= {12'hc00, pm_addr[11:0]};
      rom_q  <= {12'hb00, pm_addr[11:0]};
    end else begin
      ram0_q <= ~ram0_q;
      ram1_q <= ~ram1_q;
      rom_q  <= ~rom_q;
    end
    if (dm_rd) begin
      dram_q <= {4'h1, dm_addr[11:0]};
      per_q  <= {4'h2, dm_addr[11:0]};
      ctl_q  <= {4'h3, dm_addr[11:0]};
    end else begin
      dram_q <= ~dram_q;
      per_q  <= ~per_q;
      ctl_q  <= ~ctl_q;
    end
  end
endmodule // msd_core_mem_model

// >>> memory_space_address_decoder_bench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
module memory_space_address_decoder_bench;
  import msd_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [23:0] pm_addr = 24'h0;
  logic [15:0] dm_addr = 16'h0;
  logic        pm_rd = 1'b0, pm_wr = 1'b0, dm_rd = 1'b0, dm_wr = 1'b0;
  logic [23:0] rom_q, ram0_q, ram1_q, pm_rdata;
  logic [15:0] dram_q, per_q, ctl_q, dm_rdata;
  logic [10:0] pm_ofs;
  logic [9:0]  dm_ofs;
  logic        r0_we, r1_we, dr_we, dp_we, dc_we;
  msd_pm_sel_t pm_sel;
  msd_dm_sel_t dm_sel;
  int          errors = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  msd_core_mem_model mem (.ref_clk(ref_clk), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .dm_addr(dm_addr), .dm_rd(dm_rd), .rom_q(rom_q),
    .ram0_q(ram0_q), .ram1_q(ram1_q), .dram_q(dram_q), .per_q(per_q),
    .ctl_q(ctl_q));
  msd_decoder DUT (.ref_clk(ref_clk), .rstn(rstn), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_rom_q(rom_q), .pm_ram0_q(ram0_q),
    .pm_ram1_q(ram1_q), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_ram_q(dram_q), .dm_per_q(per_q), .dm_ctl_q(ctl_q),
    .pm_sel(pm_sel), .pm_ram0_we(r0_we), .pm_ram1_we(r1_we),
    .pm_ofs(pm_ofs), .dm_sel(dm_sel), .dm_ram_we(dr_we),
    .dm_per_we(dp_we), .dm_ctl_we(dc_we), .dm_ofs(dm_ofs),
    .pm_rdata(pm_rdata), .dm_rdata(dm_rdata));
  // Address and expected one-hot select; both ends of each region, only the start of the program hole from 0x2000
  localparam logic [27:0] PM_TAB [10] = '{{24'h000000, 4'h8},
    {24'h0007ff, 4'h8}, {24'h000800, 4'h2}, {24'h000fff, 4'h2},
    {24'h001000, 4'h1}, {24'h0017ff, 4'h1}, {24'h001800, 4'h4},
    {24'h001fff, 4'h4}, {24'h002000, 4'h1}, {24'h010800, 4'h1}};
  localparam logic [19:0] DM_TAB [11] = '{{16'h0000, 4'h1},
    {16'h1fff, 4'h1}, {16'h2000, 4'h4}, {16'h20ff, 4'h4},
    {16'h2100, 4'h1}, {16'h37ff, 4'h1}, {16'h3800, 4'h8},
    {16'h3bff, 4'h8}, {16'h3c00, 4'h2}, {16'h3fff, 4'h2},
    {16'h7800, 4'h1}};
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic scn_pm_map();
    logic [23:0] a, e;
    logic [3:0]  s;
    for (int k = 0; k < 20; k++) begin
      {a, s} = PM_TAB[k % 10];
      @(posedge ref_clk);
      pm_addr <= a;
      pm_rd <= (k < 10);
      pm_wr <= (k >= 10);
      #1;
      chk("pm_sel", 24'(s), 24'(pm_sel));
      chk("pm_ofs", 24'(a[10:0]), 24'(pm_ofs));
      chk("pm_we", 24'({2{k >= 10}} & s[3:2]), 24'({r0_we, r1_we}));
      @(posedge ref_clk);
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      #1;
      e = s[3] ? {12'ha00, a[11:0]} : s[2] ? {12'hc00, a[11:0]} :
          s[1] ? {12'hb00, a[11:0]} : 24'h0;
      chk("pm_rdata", (k < 10) ? e : 24'h0, pm_rdata);
    end
  endtask
  task automatic scn_dm_map();
    logic [15:0] a, e;
    logic [3:0]  s;
    for (int k = 0; k < 22; k++) begin
      {a, s} = DM_TAB[k % 11];
      @(posedge ref_clk);
      dm_addr <= a;
      dm_rd <= (k < 11);
      dm_wr <= (k >= 11);
      #1;
      chk("dm_sel", 24'(s), 24'(dm_sel));
      chk("dm_ofs", 24'(a[9:0]), 24'(dm_ofs));
      chk("dm_we", 24'({3{k >= 11}} & s[3:1]), 24'({dr_we, dp_we, dc_we}));
      @(posedge ref_clk);
      dm_rd <= 1'b0;
      dm_wr <= 1'b0;
      #1;
      e = s[3] ? {4'h1, a[11:0]} : s[2] ? {4'h2, a[11:0]} :
          s[1] ? {4'h3, a[11:0]} : 16'h0;
      chk("dm_rdata", 24'((k < 11) ? e : 16'h0), 24'(dm_rdata));
    end
  endtask
  task automatic scn_reset();
    @(posedge ref_clk);
    pm_addr <= 24'h000800;
    pm_rd <= 1'b1;
    dm_addr <= 16'h3800;
    dm_rd <= 1'b1;
    @(posedge ref_clk);
    // Reset right after a read edge must drop the held select
    rstn <= 1'b0;
    #1;
    chk("pm_rdata_rst", 24'h0, pm_rdata);
    chk("dm_rdata_rst", 24'h0, 24'(dm_rdata));
    chk("pm_sel_rst", 24'h2, 24'(pm_sel));
    chk("dm_sel_rst", 24'h8, 24'(dm_sel));
    @(posedge ref_clk);
    pm_rd <= 1'b0;
    dm_rd <= 1'b0;
    rstn <= 1'b1;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    scn_pm_map();
    scn_reset();
    scn_dm_map();
    tally_and_finish();
  end
  // About 90 cycles of traffic; cut a hang well after that
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end
endmodule // memory_space_address_decoder_bench
